/* hw/ddm_exec.sv */
// Dual data move executor with APB register access
`timescale 1ns/100ps
module ddm_exec #(
   parameter int NREG = ddm_pkg::NREG
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Data memory, both lanes
   output ddm_pkg::ddm_mem_req_type dm_x_req,
   output ddm_pkg::ddm_mem_req_type dm_y_req,
   input wire logic [31:0] dm_x_rdata,
   input wire logic [31:0] dm_y_rdata,
   // Program memory, both lanes
   output ddm_pkg::ddm_mem_req_type pm_x_req,
   output ddm_pkg::ddm_mem_req_type pm_y_req,
   input wire logic [31:0] pm_x_rdata,
   input wire logic [31:0] pm_y_rdata,
   // Status
   output logic exec_busy
);

   // ****************************************
   // Storage
   // ****************************************
   logic [4:0] ctrl_q;
   logic [31:0] instr_q;
   logic [31:0] comp_lo_q;
   logic [6:0] comp_hi_q;
   logic [15:0] exec_cnt_q;
   logic [31:0] prdata_q;
   ddm_pkg::ddm_state_type state_q;
   ddm_pkg::ddm_state_type state_d;
   ddm_pkg::ddm_mem_req_type dm_x_q;
   ddm_pkg::ddm_mem_req_type dm_y_q;
   ddm_pkg::ddm_mem_req_type pm_x_q;
   ddm_pkg::ddm_mem_req_type pm_y_q;
   logic [31:0] xreg_q [NREG];
   logic [31:0] yreg_q [NREG];
   logic [31:0] ireg_q [NREG];
   logic [31:0] mreg_q [NREG];

   // ****************************************
   // Mode decode
   // ****************************************
   wire logic busy = (state_q != ddm_pkg::ST_IDLE);
   wire logic capt = (state_q == ddm_pkg::ST_CAPT);
   wire logic dual = ctrl_q[ddm_pkg::CTL_DUAL];
   wire logic bc1 = ctrl_q[ddm_pkg::CTL_BC1];
   wire logic bc9 = ctrl_q[ddm_pkg::CTL_BC9];
   wire logic [1:0] width_sel = ctrl_q[ddm_pkg::CTL_WID_LO +: 2];

   // ****************************************
   // Instruction decode
   // ****************************************
   wire logic form_short = instr_q[ddm_pkg::INS_SHORT];
   wire logic dmd = instr_q[ddm_pkg::INS_DMD]; // RULE_12
   wire logic pmd = instr_q[ddm_pkg::INS_PMD]; // RULE_13
   wire logic [3:0] dm_reg = instr_q[ddm_pkg::INS_DMREG_LO +: 4];
   wire logic [3:0] pm_reg = instr_q[ddm_pkg::INS_PMREG_LO +: 4];
   // Data side uses I0-I7/M0-M7, program side I8-I15/M8-M15
   wire logic [3:0] dm_i = {1'b0, instr_q[ddm_pkg::INS_DMI_LO+:3]}; // RULE_03
   wire logic [3:0] dm_m = {1'b0, instr_q[ddm_pkg::INS_DMM_LO+:3]}; // RULE_03
   wire logic [3:0] pm_i = {1'b1, instr_q[ddm_pkg::INS_PMI_LO+:3]}; // RULE_03
   wire logic [3:0] pm_m = {1'b1, instr_q[ddm_pkg::INS_PMM_LO+:3]}; // RULE_03

   // Broadcast only applies to reads through I1 or I9
   wire logic dm_bc = bc1 & ~dmd & (dm_i == ddm_pkg::IDX_BCAST1); // RULE_09
   wire logic pm_bc = bc9 & ~pmd & (pm_i == ddm_pkg::IDX_BCAST9); // RULE_09

   // ****************************************
   // Compute decode
   // ****************************************
   wire logic [38:0] comp_field = {comp_hi_q, comp_lo_q};
   wire logic comp_en = ~form_short & (comp_field != '0); // RULE_15 RULE_17
   wire logic [3:0] cmp_dst = comp_field[ddm_pkg::CMP_DST_LO +: 4];
   wire logic [3:0] cmp_a = comp_field[ddm_pkg::CMP_A_LO +: 4];
   wire logic [3:0] cmp_b = comp_field[ddm_pkg::CMP_B_LO +: 4];
   wire ddm_pkg::ddm_op_type cmp_op =
      ddm_pkg::ddm_op_type'(comp_field[ddm_pkg::CMP_OP_LO +: 2]);

   function automatic logic [31:0] alu(
      input ddm_pkg::ddm_op_type op,
      input logic [31:0] a,
      input logic [31:0] b
   );
      logic [31:0] r;
      r = a + b;
      case (op)
         ddm_pkg::OP_SUB: r = a - b;
         ddm_pkg::OP_AND: r = a & b;
         ddm_pkg::OP_XOR: r = a ^ b;
         default: r = a + b;
      endcase
      return r;
   endfunction

   wire logic [31:0] res_x = alu(cmp_op, xreg_q[cmp_a], xreg_q[cmp_b]);
   wire logic [31:0] res_y =
      alu(cmp_op, yreg_q[cmp_a], yreg_q[cmp_b]); // RULE_16

   // ****************************************
   // Address generation
   // ****************************************
   logic [31:0] dm_xa;
   logic [31:0] dm_ya;
   logic [31:0] dm_next;
   logic [31:0] pm_xa;
   logic [31:0] pm_ya;
   logic [31:0] pm_next;

   ddm_lane_addr #(
      .AW(32)
   ) u_dm_addr (
      .index_val(ireg_q[dm_i]),
      .modify_val(mreg_q[dm_m]),
      .bcast_rd(dm_bc),
      .width_sel(width_sel),
      .x_addr(dm_xa),
      .y_addr(dm_ya),
      .y_modify(),
      .index_next(dm_next)
   );

   ddm_lane_addr #(
      .AW(32)
   ) u_pm_addr (
      .index_val(ireg_q[pm_i]),
      .modify_val(mreg_q[pm_m]),
      .bcast_rd(pm_bc),
      .width_sel(width_sel),
      .x_addr(pm_xa),
      .y_addr(pm_ya),
      .y_modify(),
      .index_next(pm_next)
   );

   // ****************************************
   // APB decode
   // ****************************************
   wire logic apb_setup = psel & ~penable;
   wire logic apb_acc = psel & penable;
   wire logic hit_ctrl = (paddr == ddm_pkg::OFF_CTRL);
   wire logic hit_instr = (paddr == ddm_pkg::OFF_INSTR);
   wire logic hit_clo = (paddr == ddm_pkg::OFF_COMP_LO);
   wire logic hit_chi = (paddr == ddm_pkg::OFF_COMP_HI);
   wire logic hit_go = (paddr == ddm_pkg::OFF_GO);
   wire logic hit_stat = (paddr == ddm_pkg::OFF_STATUS);
   wire logic [3:0] ent = paddr[5:2];
   wire logic word_ok = (paddr[1:0] == 2'h0);
   wire logic hit_x = word_ok & (paddr[11:6] == ddm_pkg::OFF_XREG[11:6]);
   wire logic hit_y = word_ok & (paddr[11:6] == ddm_pkg::OFF_YREG[11:6]);
   wire logic hit_i = word_ok & (paddr[11:6] == ddm_pkg::OFF_IREG[11:6]);
   wire logic hit_m = word_ok & (paddr[11:6] == ddm_pkg::OFF_MREG[11:6]);
   wire logic mapped = hit_ctrl | hit_instr | hit_clo | hit_chi | hit_go |
      hit_stat | hit_x | hit_y | hit_i | hit_m;
   // State must not move under a running instruction, so writes other than to status are refused with pslverr
   wire logic wr_refused = pwrite & busy & ~hit_stat;
   wire logic bad = ~mapped | wr_refused;
   wire logic reg_wr = apb_acc & pwrite & ~bad;
   wire logic go_start = reg_wr & hit_go & pwdata[ddm_pkg::GO_BIT];

   wire logic [31:0] status_word =
      {exec_cnt_q, 15'h0000, busy};
   wire logic [31:0] rd_data =
      hit_ctrl ? {27'h0000000, ctrl_q} :
      hit_instr ? instr_q :
      hit_clo ? comp_lo_q :
      hit_chi ? {25'h0000000, comp_hi_q} :
      hit_stat ? status_word :
      hit_x ? xreg_q[ent] :
      hit_y ? yreg_q[ent] :
      hit_i ? ireg_q[ent] :
      hit_m ? mreg_q[ent] :
      32'h00000000;

   assign pready = 1'b1;
   assign pslverr = apb_acc & bad;
   assign prdata = prdata_q;
   assign exec_busy = busy;

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= ddm_pkg::CTRL_RST;
         instr_q <= ddm_pkg::INSTR_RST;
         comp_lo_q <= ddm_pkg::COMP_LO_RST;
         comp_hi_q <= ddm_pkg::COMP_HI_RST;
         prdata_q <= 32'h00000000;
      end else begin
         if (reg_wr & hit_ctrl) begin
            ctrl_q <= pwdata[4:0];
         end
         if (reg_wr & hit_instr) begin
            instr_q <= pwdata;
         end
         if (reg_wr & hit_clo) begin
            comp_lo_q <= pwdata;
         end
         if (reg_wr & hit_chi) begin
            comp_hi_q <= pwdata[6:0];
         end
         if (apb_setup & ~pwrite) begin
            prdata_q <= rd_data;
         end
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         ddm_pkg::ST_IDLE: begin
            if (go_start) begin
               state_d = ddm_pkg::ST_ISSUE;
            end
         end
         ddm_pkg::ST_ISSUE: state_d = ddm_pkg::ST_CAPT;
         default: state_d = ddm_pkg::ST_IDLE;
      endcase
   end

   // Broadcast reads need one fetch only; its data feeds both lanes
   wire logic dm_y_on = dual & ~dm_bc; // RULE_04 RULE_10
   wire logic pm_y_on = dual & ~pm_bc; // RULE_04 RULE_10

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ddm_pkg::ST_IDLE;
         exec_cnt_q <= 16'h0000;
         dm_x_q <= ddm_pkg::MEM_REQ_RST;
         dm_y_q <= ddm_pkg::MEM_REQ_RST;
         pm_x_q <= ddm_pkg::MEM_REQ_RST;
         pm_y_q <= ddm_pkg::MEM_REQ_RST;
      end else begin
         state_q <= state_d;
         if (go_start) begin
            // Both sides issue together, each in its own direction
            dm_x_q <= '{1'b1, dmd, dm_xa, xreg_q[dm_reg]}; // RULE_01 RULE_14
            pm_x_q <= '{1'b1, pmd, pm_xa, xreg_q[pm_reg]}; // RULE_01 RULE_14
            dm_y_q <= '{dm_y_on, dmd, dm_ya, yreg_q[dm_reg]}; // RULE_08
            pm_y_q <= '{pm_y_on, pmd, pm_ya, yreg_q[pm_reg]}; // RULE_08
         end else begin
            dm_x_q <= ddm_pkg::MEM_REQ_RST;
            dm_y_q <= ddm_pkg::MEM_REQ_RST;
            pm_x_q <= ddm_pkg::MEM_REQ_RST;
            pm_y_q <= ddm_pkg::MEM_REQ_RST;
         end
         if (capt) begin
            exec_cnt_q <= exec_cnt_q + 16'h0001;
         end
      end
   end

   assign dm_x_req = dm_x_q;
   assign dm_y_req = dm_y_q;
   assign pm_x_req = pm_x_q;
   assign pm_y_req = pm_y_q;

   // ****************************************
   // Register file entries
   // ****************************************
   // Loads land after compute on the same register: memory wins
   for (genvar g = 0; g < NREG; g++) begin : g_ent
      wire logic [3:0] me = 4'(g);
      wire logic cmp_x = capt & comp_en & (cmp_dst == me);
      wire logic dml_x = capt & ~dmd & (dm_reg == me); // RULE_12
      wire logic pml_x = capt & ~pmd & (pm_reg == me); // RULE_13
      wire logic cmp_y = cmp_x & dual; // RULE_16
      wire logic dml_y = dml_x & (dual | dm_bc); // RULE_04 RULE_11
      wire logic pml_y = pml_x & (dual | pm_bc); // RULE_04 RULE_11
      wire logic [31:0] dm_y_val = dm_bc ? dm_x_rdata : dm_y_rdata; // RULE_11
      wire logic [31:0] pm_y_val = pm_bc ? pm_x_rdata : pm_y_rdata; // RULE_11
      wire logic idx_dm = capt & (dm_i == me); // RULE_18
      wire logic idx_pm = capt & (pm_i == me); // RULE_18
      wire logic [31:0] x_d =
         pml_x ? pm_x_rdata :
         dml_x ? dm_x_rdata :
         cmp_x ? res_x :
         (reg_wr & hit_x & (ent == me)) ? pwdata :
         xreg_q[g];
      wire logic [31:0] y_d =
         pml_y ? pm_y_val :
         dml_y ? dm_y_val :
         cmp_y ? res_y :
         (reg_wr & hit_y & (ent == me)) ? pwdata :
         yreg_q[g];
      // Only the first lane's post-modify reaches the index
      wire logic [31:0] i_d =
         idx_dm ? dm_next :
         idx_pm ? pm_next :
         (reg_wr & hit_i & (ent == me)) ? pwdata :
         ireg_q[g]; // RULE_02 RULE_07 RULE_18
      wire logic [31:0] m_d =
         (reg_wr & hit_m & (ent == me)) ? pwdata : mreg_q[g];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            xreg_q[g] <= 32'h00000000;
            yreg_q[g] <= 32'h00000000;
            ireg_q[g] <= 32'h00000000;
            mreg_q[g] <= 32'h00000000;
         end else begin
            xreg_q[g] <= x_d;
            yreg_q[g] <= y_d;
            ireg_q[g] <= i_d;
            mreg_q[g] <= m_d;
         end
      end
   end

endmodule // ddm_exec

/* hw/ddm_lane_addr.sv */
// Address generation for one memory side, both lanes
`timescale 1ns/100ps
module ddm_lane_addr #(
   parameter int AW = 32
) (
   // Index and modify values
   input wire logic [AW-1:0] index_val,
   input wire logic [AW-1:0] modify_val,
   // Mode
   input wire logic bcast_rd,
   input wire logic [1:0] width_sel,
   // Results
   output logic [AW-1:0] x_addr,
   output logic [AW-1:0] y_addr,
   output logic [AW-1:0] y_modify,
   output logic [AW-1:0] index_next
);

   // ****************************************
   // Offset selection
   // ****************************************
   // Reserved width code falls back to normal words
   wire logic [AW-1:0] k_val =
      bcast_rd ? AW'(ddm_pkg::K_BCAST) : // RULE_10
      (width_sel == ddm_pkg::WID_SHORT) ? AW'(ddm_pkg::K_SHORT) :
      (width_sel == ddm_pkg::WID_BYTE) ? AW'(ddm_pkg::K_BYTE) :
      AW'(ddm_pkg::K_NORMAL); // RULE_06

   // ****************************************
   // Addresses
   // ****************************************
   assign x_addr = index_val; // RULE_02
   assign y_addr = index_val + k_val; // RULE_05
   assign y_modify = AW'(ddm_pkg::Y_MODIFY); // RULE_07
   assign index_next = index_val + modify_val; // RULE_02

endmodule // ddm_lane_addr

/* inc/ddm_pkg.sv */
// Package: constants, carriers and states of the dual data move executor
//
// Functional notes
// RULE_01: One data and one program access per instruction
// RULE_02: Address with index, then index plus modify
// RULE_03: Data side first generator, program side second
// RULE_04: Dual lane: both elements transfer same cycle
// RULE_05: Second element addresses index plus offset k
// RULE_06: k is 1 normal, 2 short, 4 byte
// RULE_07: Second element uses zero modify value
// RULE_08: Second element uses complementary data register
// RULE_09: Broadcast bits share index address for I1/I9
// RULE_10: Broadcast read uses k of zero
// RULE_11: Broadcast read loads both lanes same value
// RULE_12: Data direction 0 load, 1 store
// RULE_13: Program direction 0 load, 1 store, independent
// RULE_14: Directions of both transfers may differ
// RULE_15: All-zero compute field means no computation
// RULE_16: Dual lane compute also writes complementary destination
// RULE_17: Short form has no compute, transfers only
// RULE_18: Each named index written back once
package ddm_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int DATA_W = 32;
   localparam int PADDR_W = 12;
   localparam int NREG = 16;
   localparam int COMP_W = 39;
   localparam int CNT_W = 16;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_INSTR = 12'h004;
   localparam logic [11:0] OFF_COMP_LO = 12'h008;
   localparam logic [11:0] OFF_COMP_HI = 12'h00c;
   localparam logic [11:0] OFF_GO = 12'h010;
   localparam logic [11:0] OFF_STATUS = 12'h014;
   localparam logic [11:0] OFF_XREG = 12'h040;
   localparam logic [11:0] OFF_YREG = 12'h080;
   localparam logic [11:0] OFF_IREG = 12'h0c0;
   localparam logic [11:0] OFF_MREG = 12'h100;

   // ****************************************
   // Control fields (core_mode_control_one)
   // ****************************************
   localparam int CTL_DUAL = 0;
   localparam int CTL_BC1 = 1;
   localparam int CTL_BC9 = 2;
   localparam int CTL_WID_LO = 3;
   localparam int CTL_W = 5;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [1:0] WID_NORMAL = 2'h0;
   localparam logic [1:0] WID_SHORT = 2'h1;
   localparam logic [1:0] WID_BYTE = 2'h2;
   localparam logic [31:0] K_NORMAL = 32'h00000001;
   localparam logic [31:0] K_SHORT = 32'h00000002;
   localparam logic [31:0] K_BYTE = 32'h00000004;
   localparam logic [31:0] K_BCAST = 32'h00000000;
   localparam logic [31:0] Y_MODIFY = 32'h00000000;
   localparam logic [3:0] IDX_BCAST1 = 4'h1;
   localparam logic [3:0] IDX_BCAST9 = 4'h9;

   // ****************************************
   // Instruction and compute fields
   // ****************************************
   localparam int INS_PMREG_LO = 0;
   localparam int INS_DMREG_LO = 4;
   localparam int INS_PMM_LO = 8;
   localparam int INS_PMI_LO = 11;
   localparam int INS_DMM_LO = 14;
   localparam int INS_DMI_LO = 17;
   localparam int INS_PMD = 20;
   localparam int INS_DMD = 21;
   localparam int INS_SHORT = 22;
   localparam logic [31:0] INSTR_RST = 32'h00000000;
   localparam logic [31:0] COMP_LO_RST = 32'h00000000;
   localparam logic [6:0] COMP_HI_RST = 7'h00;
   localparam int CMP_DST_LO = 0;
   localparam int CMP_A_LO = 4;
   localparam int CMP_B_LO = 8;
   localparam int CMP_OP_LO = 12;
   localparam int ST_BUSY = 0;
   localparam int ST_CNT_LO = 16;
   localparam int GO_BIT = 0;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ddm_mem_req_type;

   localparam ddm_mem_req_type MEM_REQ_RST = '0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_CAPT = 2'b11
   } ddm_state_type;

   typedef enum logic [1:0] {
      OP_ADD = 2'b00,
      OP_SUB = 2'b01,
      OP_AND = 2'b10,
      OP_XOR = 2'b11
   } ddm_op_type;

endpackage

/* verif/ddm_exec_chk.sv */
// Port checker for the dual data move executor
`timescale 1ns/100ps
module ddm_exec_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Memory requests
   input wire ddm_pkg::ddm_mem_req_type dm_x_req,
   input wire ddm_pkg::ddm_mem_req_type dm_y_req,
   input wire ddm_pkg::ddm_mem_req_type pm_x_req,
   input wire ddm_pkg::ddm_mem_req_type pm_y_req,
   // Status
   input wire logic exec_busy
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire go_w = psel && penable && pwrite && paddr == ddm_pkg::OFF_GO;
   wire [31:0] dm_dif = dm_y_req.addr - dm_x_req.addr;
   wire [31:0] pm_dif = pm_y_req.addr - pm_x_req.addr;

   a_go_issue:
   assert property (go_w && pwdata[0] && !exec_busy |=> exec_busy &&
      dm_x_req.valid && pm_x_req.valid) else $error("go did not issue");
   a_issue_once:
   assert property ($fell(exec_busy) |-> $past(dm_x_req.valid, 2) &&
      $past(pm_x_req.valid, 2)) else $error("busy without issue");
   a_busy_span:
   assert property ($rose(exec_busy) |-> exec_busy[*2] ##1 !exec_busy)
      else $error("busy length wrong");
   a_go_refused:
   assert property (go_w && exec_busy |-> pslverr)
      else $error("go while busy accepted");
   a_dm_y_offset:
   assert property (dm_y_req.valid |-> dm_x_req.valid &&
      dm_y_req.we == dm_x_req.we &&
      (dm_dif == 32'h1 || dm_dif == 32'h2 || dm_dif == 32'h4))
      else $error("data y lane address wrong");
   a_pm_y_offset:
   assert property (pm_y_req.valid |-> pm_x_req.valid &&
      pm_y_req.we == pm_x_req.we &&
      (pm_dif == 32'h1 || pm_dif == 32'h2 || pm_dif == 32'h4))
      else $error("program y lane address wrong");
   a_req_pulse:
   assert property (dm_x_req.valid |=> !dm_x_req.valid && !pm_x_req.valid)
      else $error("request longer than one cycle");
   a_req_start:
   assert property (dm_x_req.valid || pm_x_req.valid |->
      exec_busy && !$past(exec_busy)) else $error("request out of place");
   a_err_phase:
   assert property (pslverr |-> psel && penable && pready)
      else $error("error outside access phase");
endmodule // ddm_exec_chk

bind ddm_exec ddm_exec_chk i_ddm_exec_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .dm_x_req(dm_x_req), .dm_y_req(dm_y_req),
   .pm_x_req(pm_x_req), .pm_y_req(pm_y_req), .exec_busy(exec_busy)
);

/* verif/ddm_mem.sv */
// Behavioural data and program memories for both lanes
`timescale 1ns/100ps
module ddm_mem (
   // Clock
   input wire logic pclk,
   // Requests
   input wire ddm_pkg::ddm_mem_req_type dx,
   input wire ddm_pkg::ddm_mem_req_type dy,
   input wire ddm_pkg::ddm_mem_req_type px,
   input wire ddm_pkg::ddm_mem_req_type py,
   // Read data
   output logic [31:0] dxr,
   output logic [31:0] dyr,
   output logic [31:0] pxr,
   output logic [31:0] pyr
);
   logic [31:0] dm [256];
   logic [31:0] pm [256];
   initial {dxr, dyr, pxr, pyr} = '0;
   // Idle data toggles, so a late sample never looks right
   always @(posedge pclk) begin
      dxr <= (dx.valid && !dx.we) ? dm[dx.addr[7:0]] : ~dxr;
      dyr <= (dy.valid && !dy.we) ? dm[dy.addr[7:0]] : ~dyr;
      pxr <= (px.valid && !px.we) ? pm[px.addr[7:0]] : ~pxr;
      pyr <= (py.valid && !py.we) ? pm[py.addr[7:0]] : ~pyr;
      if (dx.valid && dx.we) dm[dx.addr[7:0]] <= dx.wdata;
      if (dy.valid && dy.we) dm[dy.addr[7:0]] <= dy.wdata;
      if (px.valid && px.we) pm[px.addr[7:0]] <= px.wdata;
      if (py.valid && py.we) pm[py.addr[7:0]] <= py.wdata;
   end
endmodule // ddm_mem

/* verif/tb_top.sv */
// Self-checking bench for the dual data move executor
`timescale 1ns/100ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, dxr, dyr, pxr, pyr, rd;
   logic pready, pslverr, exec_busy, er;
   ddm_pkg::ddm_mem_req_type dxq, dyq, pxq, pyq;
   logic [31:0] ex [16], ey [16], ei [16], em [16], edm [256], epm [256];
   int miscompares = 0;
   int tests_run = 0;
   int cnt = 0;

   ddm_exec i_ddm_exec (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dm_x_req(dxq), .dm_y_req(dyq), .dm_x_rdata(dxr), .dm_y_rdata(dyr),
      .pm_x_req(pxq), .pm_y_req(pyq), .pm_x_rdata(pxr), .pm_y_rdata(pyr),
      .exec_busy(exec_busy));
   ddm_mem i_ddm_mem (.pclk(pclk), .dx(dxq), .dy(dyq), .px(pxq), .py(pyq),
      .dxr(dxr), .dyr(dyr), .pxr(pxr), .pyr(pyr));

   initial forever #20 pclk = ~pclk;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   // Keep holds psel so a second transfer follows with no idle cycle
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input bit keep);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      penable <= 1'b0;
      // Release lets an edge pass so psel is never set twice at once
      if (!keep) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rd_chk(input string n, input logic [11:0] a,
         input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(n, e, rd);
   endtask

   function automatic int koff(input logic [1:0] w);
      return w == 2'h1 ? 2 : w == 2'h2 ? 4 : 1;
   endfunction

   function automatic logic [31:0] alu(input logic [1:0] op,
         input logic [31:0] a, input logic [31:0] b);
      case (op)
         2'h0: return a + b;
         2'h1: return a - b;
         2'h2: return a & b;
         default: return a ^ b;
      endcase
   endfunction

   // ****************************************
   // One instruction, random with corners
   // ****************************************
   task automatic run_one(input int it);
      bit dual, bc1, bc9, sh, dmd, pmd, bd, bp;
      logic [1:0] wid;
      logic [2:0] dmi, dmm, pmi, pmm;
      logic [3:0] dmr, pmr;
      logic [13:0] cmp;
      logic [6:0] chi;
      logic [31:0] tx, ty;
      int k, ia, ic;
      {dual, bc1, bc9, sh, dmd, pmd} = 6'($urandom);
      {wid, dmi, dmm, pmi, pmm, dmr, pmr} = 22'($urandom);
      cmp = 14'($urandom);
      if (it == 0) {dual, sh, dmd, pmd} = 4'b0101;
      if (it == 1) {dual, sh, cmp} = {2'b10, 14'h0};
      if (it == 2) {dual, bc1, dmi, dmd, wid} = {5'b11001, 1'b0, 2'h1};
      if (it == 3) {dual, bc9, pmi, pmd} = {5'b01001, 1'b0};
      if (it == 4) {dual, wid, dmd, pmd} = 5'b11011;
      // Compute enabled by the upper field bits alone
      if (it == 5) {sh, cmp} = 15'h0;
      chi = 7'(it == 5);
      for (int n = 0; n < 16; n++) begin
         ex[n] = $urandom;
         ey[n] = $urandom;
         ei[n] = $urandom_range(63);
         em[n] = $urandom_range(15);
         wr(ddm_pkg::OFF_XREG + 12'(4 * n), ex[n]);
         wr(ddm_pkg::OFF_YREG + 12'(4 * n), ey[n]);
         wr(ddm_pkg::OFF_IREG + 12'(4 * n), ei[n]);
         wr(ddm_pkg::OFF_MREG + 12'(4 * n), em[n]);
      end
      wr(ddm_pkg::OFF_CTRL, {27'h0, wid, bc9, bc1, dual});
      wr(ddm_pkg::OFF_INSTR, {9'h0, sh, dmd, pmd, dmi, dmm, pmi, pmm, dmr,
         pmr});
      wr(ddm_pkg::OFF_COMP_LO, {18'h0, cmp});
      wr(ddm_pkg::OFF_COMP_HI, {25'h0, chi});
      k = koff(wid);
      ia = ei[dmi];
      ic = ei[8 + pmi];
      bd = !dmd && bc1 && dmi == 3'h1;
      bp = !pmd && bc9 && pmi == 3'h1;
      // Stores first, since they carry pre-instruction values
      if (dmd) edm[ia] = ex[dmr];
      if (dmd && dual) edm[ia + k] = ey[dmr];
      if (pmd) epm[ic] = ex[pmr];
      if (pmd && dual) epm[ic + k] = ey[pmr];
      tx = alu(cmp[13:12], ex[cmp[7:4]], ex[cmp[11:8]]);
      ty = alu(cmp[13:12], ey[cmp[7:4]], ey[cmp[11:8]]);
      if (!sh && {chi, cmp} != 21'h0) ex[cmp[3:0]] = tx;
      if (!sh && {chi, cmp} != 21'h0 && dual) ey[cmp[3:0]] = ty;
      if (!dmd) ex[dmr] = edm[ia];
      if (!dmd && (dual || bd)) ey[dmr] = bd ? edm[ia] : edm[ia + k];
      if (!pmd) ex[pmr] = epm[ic];
      if (!pmd && (dual || bp)) ey[pmr] = bp ? epm[ic] : epm[ic + k];
      ei[dmi] = ei[dmi] + em[dmm];
      ei[8 + pmi] = ei[8 + pmi] + em[8 + pmm];
      cnt++;
      apb(1'b1, ddm_pkg::OFF_GO, 32'h1, 1'b1);
      apb(1'b1, ddm_pkg::OFF_GO, 32'h1, 1'b0);
      chk("go while busy", 32'h1, {31'h0, er});
      for (int w = 0; w < 20 && exec_busy !== 1'b0; w++) @(posedge pclk);
      chk("busy end", 32'h0, {31'h0, exec_busy});
      for (int n = 0; n < 16; n++) begin
         rd_chk("xreg", ddm_pkg::OFF_XREG + 12'(4 * n), ex[n]);
         rd_chk("yreg", ddm_pkg::OFF_YREG + 12'(4 * n), ey[n]);
         rd_chk("ireg", ddm_pkg::OFF_IREG + 12'(4 * n), ei[n]);
      end
      for (int a = 0; a < 256; a++) begin
         chk("dmem", edm[a], i_ddm_mem.dm[a]);
         chk("pmem", epm[a], i_ddm_mem.pm[a]);
      end
      rd_chk("count", ddm_pkg::OFF_STATUS, {16'(cnt), 16'h0});
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      void'($urandom(10341));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk("ctrl reset", ddm_pkg::OFF_CTRL, 32'h0);
      rd_chk("status reset", ddm_pkg::OFF_STATUS, 32'h0);
      apb(1'b0, 12'h3f0, 32'h0, 1'b0);
      chk("unmapped", 32'h1, {31'h0, er});
      for (int a = 0; a < 256; a++) begin
         edm[a] = $urandom;
         epm[a] = $urandom;
         i_ddm_mem.dm[a] = edm[a];
         i_ddm_mem.pm[a] = epm[a];
      end
      for (int it = 0; it < 24; it++) run_one(it);
      test_done;
   end

   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      test_done;
   end
endmodule // tb_top
